/* File: logic/eeprom_protect_ctrl.v */
// Command decoder, status register, protection and erase control
`timescale 1ns/1ps
`include "eeprom_ctrl_defs.vh"

module eeprom_protect_ctrl #(
    parameter ERASE_CYC  = `ERASE_CYCLES,
    parameter SETTLE_CYC = `SETTLE_CYCLES,
    parameter WAKE_CYC   = `WAKE_CYCLES,
    parameter ADDR_W     = 16,
    parameter PAGE_W     = 7,
    parameter SIG_VALUE  = 8'h5A
)(
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              cs_n_i,
    input  wire              sck_i,
    input  wire              si_i,
    input  wire              guard_pin_n_i,
    output reg               so_o,
    output reg               so_oe_o,
    output reg  [7:0]        status_o,
    output reg               erase_start_o,
    output reg  [1:0]        erase_kind_o,
    output reg  [ADDR_W-1:0] erase_lo_o,
    output reg  [ADDR_W-1:0] erase_hi_o,
    output reg               write_start_o,
    output reg               asleep_o
);
    // Internal job states, one-hot
    localparam S_IDLE   = 4'b0001;
    localparam S_BUSY   = 4'b0010;
    localparam S_SETTLE = 4'b0100;
    localparam S_WAKE   = 4'b1000;

    localparam K_PAGE = 2'h0;
    localparam K_QUAR = 2'h1;
    localparam K_FULL = 2'h2;
    localparam K_STAT = 2'h3;

    reg  [2:0]  cs_s_r;
    reg  [2:0]  sck_s_r;
    reg  [1:0]  si_s_r;
    reg  [1:0]  wp_s_r;
    reg  [5:0]  bitcnt_r;
    reg  [7:0]  op_r;
    reg  [15:0] addr_r;
    reg  [7:0]  data_r;
    reg  [7:0]  shout_r;
    reg         latch_r;
    reg  [2:0]  nv_r;
    reg  [3:0]  state_r;
    reg  [31:0] cnt_r;
    reg         sleep_r;
    reg  [1:0]  job_r;
    reg  [7:0]  new_sr_r;

    // Address lies in a guarded region
    function guarded;
        input [1:0]  g;
        input [15:0] a;
        begin
            case (g)
                2'b01:   guarded = (a[15:14] == `QUARTER_HI_BASE);
                2'b10:   guarded = (a[15] == `HALF_HI_BASE);
                2'b11:   guarded = 1'b1;
                default: guarded = 1'b0;
            endcase
        end
    endfunction

    wire cs_n    = cs_s_r[1];
    wire sck_n   = sck_s_r[1];
    wire sck_rise = sck_n & ~sck_s_r[2] & ~cs_n;
    wire sck_fall = ~sck_n & sck_s_r[2] & ~cs_n;
    wire cs_rise = cs_n & ~cs_s_r[2];
    wire cs_fall = ~cs_n & cs_s_r[2];
    wire busy    = (state_r == S_BUSY);
    wire [7:0] op_next = {op_r[6:0], si_s_r[1]};
    wire hw_guard = ~wp_s_r[1] & nv_r[2];
    wire [1:0] g = nv_r[1:0];
    wire [7:0] sr = {nv_r[2], 3'h0, nv_r[1:0], latch_r, busy};
    wire [15:0] a_lo_page = {addr_r[15:PAGE_W], {PAGE_W{1'b0}}};
    wire [15:0] a_hi_page = {addr_r[15:PAGE_W], {PAGE_W{1'b1}}};

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_s_r  <= 3'h7;
            sck_s_r <= 3'h0;
            si_s_r  <= 2'h0;
            wp_s_r  <= 2'h3;
        end
        else
        begin
            cs_s_r  <= {cs_s_r[1:0], cs_n_i};
            sck_s_r <= {sck_s_r[1:0], sck_i};
            si_s_r  <= {si_s_r[0], si_i};
            wp_s_r  <= {wp_s_r[0], guard_pin_n_i};
        end
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bitcnt_r      <= 6'h00;
            op_r          <= 8'h00;
            addr_r        <= 16'h0000;
            data_r        <= 8'h00;
            shout_r       <= 8'h00;
            latch_r       <= 1'b0;
            nv_r          <= 3'h0;
            state_r       <= S_IDLE;
            cnt_r         <= 32'h0;
            sleep_r       <= 1'b0;
            job_r         <= K_PAGE;
            new_sr_r      <= 8'h00;
            so_o          <= 1'b0;
            so_oe_o       <= 1'b0;
            status_o      <= `SR_RESET;
            erase_start_o <= 1'b0;
            erase_kind_o  <= K_PAGE;
            erase_lo_o    <= {ADDR_W{1'b0}};
            erase_hi_o    <= {ADDR_W{1'b0}};
            write_start_o <= 1'b0;
            asleep_o      <= 1'b0;
        end
        else
        begin
            erase_start_o <= 1'b0;
            write_start_o <= 1'b0;
            status_o      <= sr;
            asleep_o      <= sleep_r;
            if (cs_fall)
            begin
                bitcnt_r <= 6'h00;
                so_oe_o  <= 1'b0;
            end
            if (cs_n)
                so_oe_o <= 1'b0;
            if (sck_rise)
            begin
                if (bitcnt_r != 6'h3F)
                    bitcnt_r <= bitcnt_r + 6'h01;
                if (bitcnt_r < 6'h08)
                    op_r <= op_next;
                else if (bitcnt_r < 6'h18)
                    addr_r <= {addr_r[14:0], si_s_r[1]};
                if (bitcnt_r >= 6'h08 && bitcnt_r < 6'h10)
                    data_r <= {data_r[6:0], si_s_r[1]};
                // Status read answered even while busy
                if (bitcnt_r == 6'h07 && !sleep_r
                    && op_next == `OP_STATUS_READ)
                    shout_r <= sr;
                if (bitcnt_r == 6'h17 && op_r == `OP_WAKE_SIG)
                    shout_r <= SIG_VALUE;
            end
            if (sck_fall && bitcnt_r >= 6'h08)
            begin
                if ((op_r == `OP_STATUS_READ && !sleep_r)
                    || (op_r == `OP_WAKE_SIG && bitcnt_r >= 6'h18))
                begin
                    so_oe_o <= 1'b1;
                    so_o    <= shout_r[7];
                    shout_r <= (op_r == `OP_WAKE_SIG) ?
                        {shout_r[6:0], shout_r[7]} :
                        {shout_r[6:0], shout_r[7]};
                end
            end
            // Commands act on deselect, bit count must match exactly except array write (32 to 56, whole bytes) and wake (8 or more)
            if (cs_rise && sleep_r)
            begin
                if (op_r == `OP_WAKE_SIG && bitcnt_r >= 6'h08)
                begin
                    state_r <= S_WAKE;
                    cnt_r   <= 32'h0;
                end
            end
            // Only idle takes commands, except wake, which is taken in any state while asleep, so busy timing never stalls
            else if (cs_rise && state_r == S_IDLE)
            begin
                case (op_r)
                    `OP_LATCH_SET:
                        if (bitcnt_r == 6'h08 && !busy)
                            latch_r <= 1'b1;
                    `OP_LATCH_CLEAR:
                        if (bitcnt_r == 6'h08 && !busy)
                            latch_r <= 1'b0;
                    `OP_STATUS_WRITE:
                        if (bitcnt_r == 6'h10 && !busy && latch_r
                            && !hw_guard)
                        begin
                            new_sr_r <= data_r;
                            job_r    <= K_STAT;
                            state_r  <= S_BUSY;
                            cnt_r    <= 32'h0;
                        end
                    `OP_PAGE_CLEAR, `OP_QUARTER_CLEAR:
                        if (bitcnt_r == 6'h18 && !busy && latch_r
                            && !guarded(g, addr_r))
                        begin
                            erase_start_o <= 1'b1;
                            state_r       <= S_BUSY;
                            cnt_r         <= 32'h0;
                            if (op_r == `OP_PAGE_CLEAR)
                            begin
                                job_r        <= K_PAGE;
                                erase_kind_o <= K_PAGE;
                                erase_lo_o   <= a_lo_page;
                                erase_hi_o   <= a_hi_page;
                            end
                            else
                            begin
                                job_r        <= K_QUAR;
                                erase_kind_o <= K_QUAR;
                                erase_lo_o   <= {addr_r[15:14], 14'h0000};
                                erase_hi_o   <= {addr_r[15:14], 14'h3FFF};
                            end
                        end
                    `OP_FULL_CLEAR:
                        if (bitcnt_r == 6'h08 && !busy && latch_r
                            && g == 2'b00)
                        begin
                            erase_start_o <= 1'b1;
                            job_r         <= K_FULL;
                            erase_kind_o  <= K_FULL;
                            erase_lo_o    <= 16'h0000;
                            erase_hi_o    <= 16'hFFFF;
                            state_r       <= S_BUSY;
                            cnt_r         <= 32'h0;
                        end
                    `OP_ARRAY_WRITE:
                        if (bitcnt_r >= 6'h20 && bitcnt_r[2:0] == 3'h0
                            && !busy && latch_r
                            && !guarded(g, addr_r))
                        begin
                            write_start_o <= 1'b1;
                            job_r         <= K_PAGE;
                            state_r       <= S_BUSY;
                            cnt_r         <= 32'h0;
                        end
                    `OP_SLEEP_ENTRY:
                        if (bitcnt_r == 6'h08 && !busy)
                        begin
                            sleep_r <= 1'b1;
                            state_r <= S_SETTLE;
                            cnt_r   <= 32'h0;
                        end
                    default:
                        cnt_r <= cnt_r;
                endcase
            end
            else
            begin
                case (state_r)
                    S_IDLE:
                        cnt_r <= 32'h0;
                    S_BUSY:
                        if (cnt_r >= ERASE_CYC - 1)
                        begin
                            state_r <= S_IDLE;
                            latch_r <= 1'b0;
                            if (job_r == K_STAT)
                                nv_r <= {new_sr_r[`SR_HW_GUARD_EN],
                                         new_sr_r[`SR_GUARD_HI],
                                         new_sr_r[`SR_GUARD_LO]};
                        end
                        else
                            cnt_r <= cnt_r + 32'h1;
                    S_SETTLE:
                        if (cnt_r >= SETTLE_CYC - 1)
                            state_r <= S_IDLE;
                        else
                            cnt_r <= cnt_r + 32'h1;
                    S_WAKE:
                        if (cnt_r >= WAKE_CYC - 1)
                        begin
                            state_r <= S_IDLE;
                            sleep_r <= 1'b0;
                        end
                        else
                            cnt_r <= cnt_r + 32'h1;
                    default:
                        state_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: logic/eeprom_ctrl_defs.vh */
// Opcodes, status layout, protection and timing constants
`ifndef EEPROM_CTRL_DEFS_VH
`define EEPROM_CTRL_DEFS_VH

`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_ARRAY_WRITE   8'h02
`define OP_PAGE_CLEAR    8'h42
`define OP_QUARTER_CLEAR 8'hD8
`define OP_FULL_CLEAR    8'hC7
`define OP_SLEEP_ENTRY   8'hB9
`define OP_WAKE_SIG      8'hAB

`define SR_HW_GUARD_EN   7
`define SR_GUARD_HI      3
`define SR_GUARD_LO      2
`define SR_LATCH         1
`define SR_BUSY          0
`define SR_WRITE_MASK    8'h8C
`define SR_RESET         8'h00

`define QUARTER_HI_BASE  2'h3
`define HALF_HI_BASE     1'h1

`define CLK_PERIOD_NS    10
`define ERASE_TIME_NS    5000
`define ERASE_CYCLES     ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_TIME_NS   3000
`define SETTLE_CYCLES    ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_TIME_NS     3000
`define WAKE_CYCLES      ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verification/eeprom_ctrl_monitor.sv */
// Port-level assertions for the protection and erase controller
`timescale 1ns/1ps
module eeprom_ctrl_monitor #(
    parameter ERASE_CYC = 500
)(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cs_n_i,
    input wire logic [7:0]  status_o,
    input wire logic        erase_start_o,
    input wire logic [1:0]  erase_kind_o,
    input wire logic [15:0] erase_lo_o,
    input wire logic [15:0] erase_hi_o,
    input wire logic        write_start_o,
    input wire logic        asleep_o
);
    localparam int BMIN = ERASE_CYC - 1;
    localparam int BMAX = ERASE_CYC + 2;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence busy_rise;
        $rose(status_o[0]);
    endsequence
    sequence busy_done;
        ##[BMIN:BMAX] $fell(status_o[0]);
    endsequence
    chk_busy_len: assert property (busy_rise |-> busy_done)
        else $error("busy cycle length wrong");
    chk_launch_latch: assert property (erase_start_o |->
        status_o[1] && !status_o[0]) else $error("erase launched wrongly");
    chk_busy_follow: assert property (erase_start_o |-> ##[1:3]
        status_o[0]) else $error("busy not raised by erase");
    chk_latch_drop: assert property ($fell(status_o[0]) |-> ##[0:1]
        !status_o[1]) else $error("latch kept after cycle");
    chk_full_guard: assert property (erase_start_o &&
        erase_kind_o == 2'h2 |-> status_o[3:2] == 2'h0)
        else $error("full erase under guard");
    chk_guard_map: assert property (erase_start_o |->
        status_o[3:2] == 2'h0 ||
        (status_o[3:2] == 2'h1 && erase_hi_o < 16'hC000) ||
        (status_o[3:2] == 2'h2 && erase_hi_o < 16'h8000))
        else $error("guarded range erased");
    chk_page_span: assert property (erase_start_o &&
        erase_kind_o == 2'h0 |-> erase_lo_o[6:0] == 7'h00 &&
        erase_hi_o == (erase_lo_o | 16'h007F)) else $error("bad page span");
    chk_quarter_span: assert property (erase_start_o &&
        erase_kind_o == 2'h1 |-> erase_lo_o[13:0] == 14'h0000 &&
        erase_hi_o == (erase_lo_o | 16'h3FFF)) else $error("bad quarter");
    chk_sleep_quiet: assert property (asleep_o |->
        !erase_start_o && !write_start_o) else $error("work while asleep");
    chk_cs_launch: assert property (erase_start_o |->
        $past(cs_n_i, 3) && cs_n_i) else $error("erase before deselect");
endmodule

bind eeprom_protect_ctrl eeprom_ctrl_monitor #(.ERASE_CYC(ERASE_CYC)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .status_o(status_o),
    .erase_start_o(erase_start_o), .erase_kind_o(erase_kind_o),
    .erase_lo_o(erase_lo_o), .erase_hi_o(erase_hi_o),
    .write_start_o(write_start_o), .asleep_o(asleep_o));

/* File: verification/spi_host_model.sv */
// Host side serial master that sends framed commands
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_i,
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // Clock idles low; data line toggles once its hold is over
    task automatic xfer(input logic [31:0] d, input int n,
                        output logic [7:0] rx);
        @(posedge clk_i);
        #1 cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si_o = d[i];
            repeat (8) @(posedge clk_i);
            #1 sck_o = 1'b1;
            // Released line reads as pulled high
            rx = {rx[6:0], so_oe_i ? so_i : 1'b1};
            repeat (8) @(posedge clk_i);
            #1 sck_o = 1'b0;
            if (i == 0)
                si_o = ~si_o;
        end
        repeat (8) @(posedge clk_i);
        #1 cs_n_o = 1'b1;
        repeat (24) @(posedge clk_i);
        #1;
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the protection and erase controller
`timescale 1ns/1ps
module testbench;
    logic        clk_i;
    logic        rst_i;
    logic        guard_pin_n_i;
    wire         cs_n, sck, si, so_o, so_oe_o, ers, wst, asleep_o;
    wire  [7:0]  status_o;
    wire  [1:0]  kind;
    wire  [15:0] lo, hi;
    logic [7:0]  rx;
    logic [1:0]  ekind;
    logic [15:0] elo, ehi;
    integer      fails = 0, comparisons = 0, ecnt = 0, wcnt = 0;
    eeprom_protect_ctrl #(.ERASE_CYC(600), .SETTLE_CYC(8), .WAKE_CYC(8),
        .SIG_VALUE(8'h5A)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .guard_pin_n_i(guard_pin_n_i), .so_o(so_o),
        .so_oe_o(so_oe_o), .status_o(status_o), .erase_start_o(ers),
        .erase_kind_o(kind), .erase_lo_o(lo), .erase_hi_o(hi),
        .write_start_o(wst), .asleep_o(asleep_o));
    spi_host_model host (.clk_i(clk_i), .so_i(so_o), .so_oe_i(so_oe_o),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (ers === 1'b1)
        begin
            ecnt  <= ecnt + 1;
            ekind <= kind;
            elo   <= lo;
            ehi   <= hi;
        end
    always @(posedge clk_i)
        if (wst === 1'b1)
            wcnt <= wcnt + 1;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task x(input logic [31:0] d, input int n);
        host.xfer(d, n, rx);
    endtask
    task wait_idle;
        int k;
        k = 0;
        while (status_o[0] !== 1'b0 && k < 2000)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(k < 2000, 1);
    endtask
    task ck_erase(int n, logic [1:0] k, logic [15:0] l, logic [15:0] h);
        chk(ecnt, n);
        chk(ekind, k);
        chk(elo, l);
        chk(ehi, h);
    endtask
    task t_latch;
        x(8'h06, 8);
        chk(status_o, 8'h02);
        x(8'h04, 8);
        chk(status_o, 8'h00);
        x(32'h02001234, 32);
        chk(wcnt, 0);
        x(8'h06, 8);
        x(32'h02001234, 32);
        chk(wcnt, 1);
        chk(status_o, 8'h03);
        wait_idle();
        chk(status_o, 8'h00);
    endtask
    task t_full;
        x(8'hC7, 8);
        chk(ecnt, 0);
        x(8'h06, 8);
        x(9'h18E, 9);
        chk(ecnt, 0);
        x(8'hC7, 8);
        ck_erase(1, 2'h2, 16'h0000, 16'hFFFF);
        x(8'hC7, 8);
        x(16'h0500, 16);
        chk(rx, 8'h03);
        chk(ecnt, 1);
        wait_idle();
        chk(status_o, 8'h00);
    endtask
    task t_guard;
        x(8'h06, 8);
        x(16'h01FF, 16);
        wait_idle();
        chk(status_o, 8'h8C);
        x(8'h06, 8);
        x(8'hC7, 8);
        chk(ecnt, 1);
        x(24'h421234, 24);
        chk(ecnt, 1);
        x(16'h0184, 16);
        wait_idle();
        chk(status_o, 8'h84);
        @(posedge clk_i);
        #1 guard_pin_n_i = 1'b0;
        x(8'h06, 8);
        x(16'h0100, 16);
        chk(status_o, 8'h86);
        x(24'h421234, 24);
        ck_erase(2, 2'h0, 16'h1200, 16'h127F);
        wait_idle();
        x(8'h06, 8);
        x(24'hD8C001, 24);
        x(16'hD845, 16);
        chk(ecnt, 2);
        x(24'hD84567, 24);
        ck_erase(3, 2'h1, 16'h4000, 16'h7FFF);
        wait_idle();
    endtask
    task t_sleep;
        x(9'h172, 9);
        chk(asleep_o, 1'b0);
        x(8'hB9, 8);
        chk(asleep_o, 1'b1);
        x(8'h06, 8);
        chk(status_o, 8'h84);
        x(32'hAB000000, 32);
        chk(rx, 8'h5A);
        chk(asleep_o, 1'b0);
        x(8'h06, 8);
        chk(status_o, 8'h86);
    endtask
    initial
    begin
        rst_i = 1'b1;
        guard_pin_n_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (3) @(posedge clk_i);
        chk(status_o, 8'h00);
        t_latch();
        t_full();
        t_guard();
        t_sleep();
        close_out();
    end
    initial
    begin
        #500000;
        fails++;
        close_out();
    end
endmodule
